// >>> core/scm_mode_ctrl.sv
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`include "scm_regs.svh"
module scm_mode_ctrl
  import scm_pkg::*;
(
  // Register bus slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System and link inputs.
  input wire logic sys_idle,
  input wire logic cts_n,
  input wire logic rx_char_done,
  input wire logic rx_ninth_bit,
  input wire logic tx_busy,
  // Controls to the channel datapath.
  output logic [1:0] mode,
  output logic [1:0] clk_sel,
  output logic tx_ninth_bit,
  output logic tx_allow,
  output logic rx_allow,
  output logic rx_irq,
  output logic chan_run,
  output logic [1:0] fifo_cfg,
  output logic fifo_init,
  output logic logic_reset,
  output logic [6:0] gap_clocks
);

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [7:0] mod_a_q;
  logic [7:0] mod_b_q;
  logic [8:0] ctl_q;
  scm_sr_t sr_q;
  logic sw_fire;
  logic wr_en;
  logic rd_en;

  // Decodes a gap code into serial clocks; code 110 is not legal and gives none.
  function automatic logic [6:0] gap_decode(input logic [2:0] code);
    case (code)
      3'h1: gap_decode = `SCM_GAP_C1;
      3'h2: gap_decode = `SCM_GAP_C2;
      3'h3: gap_decode = `SCM_GAP_C4;
      3'h4: gap_decode = `SCM_GAP_C8;
      3'h5: gap_decode = `SCM_GAP_C16;
      3'h7: gap_decode = `SCM_GAP_C64;
      default: gap_decode = `SCM_GAP_NONE;
    endcase
  endfunction

  // Zero-wait slave: a transfer completes in its access cycle.
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign sw_fire = wr_en && paddr == `SCM_ADDR_CR && sr_q == SCM_SR_ARMED &&
                   pwdata[`SCM_CR_SRST +: 2] == `SCM_SRST_SECOND;

  // ------------------------------------------------------------
  // Soft reset sequencer
  // ------------------------------------------------------------
  // Only the exact pair 10 then 01 fires; any other control register write disarms.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_q <= SCM_SR_IDLE;
    end else if (wr_en && paddr == `SCM_ADDR_CR) begin
      case (pwdata[`SCM_CR_SRST +: 2])
        `SCM_SRST_FIRST: sr_q <= SCM_SR_ARMED;
        default: sr_q <= SCM_SR_IDLE;
      endcase
    end
  end

  // Mode register a; soft reset clears only the receive enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_a_q <= `SCM_RST_A;
    end else if (wr_en && paddr == `SCM_ADDR_A) begin
      mod_a_q <= pwdata[7:0];
    end else if (sw_fire) begin
      mod_a_q[`SCM_A_RXE] <= 1'b0;
    end
  end

  // Mode register b; bit 0 is kept zero since software must write zero there.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_b_q <= `SCM_RST_B;
    end else if (wr_en && paddr == `SCM_ADDR_B) begin
      mod_b_q <= {pwdata[7:1], 1'b0};
    end else if (sw_fire) begin
      mod_b_q[`SCM_B_TXE] <= 1'b0;
    end
  end

  // Control bits: clock select, clock direction, buffering, FIFO, channel enable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= `SCM_RST_CR;
    end else if (wr_en && paddr == `SCM_ADDR_CR) begin
      ctl_q <= {pwdata[`SCM_CR_SRST +: 1], 3'h0, pwdata[4:0]};
    end
  end

  // Read data is registered in the setup cycle so prdata comes from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        `SCM_ADDR_A: prdata <= {24'h00_0000, mod_a_q};
        `SCM_ADDR_B: prdata <= {24'h00_0000, mod_b_q};
        `SCM_ADDR_CR: prdata <= {27'h000_0000, ctl_q[4:0]};
        `SCM_ADDR_ST: prdata <= {29'h0000_0000, tx_busy, chan_run, fifo_init};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Slave answers in the first access cycle; unmapped addresses flag an error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > `SCM_ADDR_ST || paddr[1:0] != 2'b00);
    end
  end

  // ------------------------------------------------------------
  // Channel controls
  // ------------------------------------------------------------
  logic sync_mode;
  logic u9_mode;
  logic run_d;
  logic dir_tx_ok;
  logic dir_rx_ok;
  assign sync_mode = mod_a_q[`SCM_A_MODE +: 2] == SCM_MODE_SYNC;
  assign u9_mode = mod_a_q[`SCM_A_MODE +: 2] == SCM_MODE_U9;
  assign run_d = ctl_q[`SCM_CR_CHEN] & (~sys_idle | mod_b_q[`SCM_B_IDLE]);
  // Direction limit applies only in sync mode; UART ignores the duplex field.
  assign dir_tx_ok = ~sync_mode | mod_b_q[`SCM_B_DUPLEX + 1];
  assign dir_rx_ok = ~sync_mode | mod_b_q[`SCM_B_DUPLEX];

  // Mode, clock source and direction gates, all registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= 2'b00;
      clk_sel <= 2'b00;
      tx_ninth_bit <= 1'b0;
      tx_allow <= 1'b0;
      rx_allow <= 1'b0;
      chan_run <= 1'b0;
      fifo_cfg <= 2'b00;
    end else begin
      mode <= mod_a_q[`SCM_A_MODE +: 2];
      // Sync mode maps the control clock bit onto the baud or pin encodings.
      clk_sel <= sync_mode ? (ctl_q[`SCM_CR_SYNCCLK] ? SCM_CLK_PIN : SCM_CLK_BAUD)
                           : mod_a_q[`SCM_A_CLKSRC +: 2];
      tx_ninth_bit <= u9_mode & mod_a_q[`SCM_A_NINTH];
      // Clear-to-send is low-active; it gates only UART transmit.
      tx_allow <= run_d & mod_b_q[`SCM_B_TXE] & dir_tx_ok &
                  (sync_mode | ~mod_a_q[`SCM_A_HSHK] | ~cts_n);
      rx_allow <= run_d & mod_a_q[`SCM_A_RXE] & dir_rx_ok;
      chan_run <= run_d;
      fifo_cfg <= mod_b_q[`SCM_B_DUPLEX +: 2];
    end
  end

  // Receive interrupt with the wake-up filter, only meaningful in 9-bit mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= rx_char_done & rx_allow &
                (~(u9_mode & mod_a_q[`SCM_A_WAKE]) | rx_ninth_bit);
    end
  end

  // FIFO re-init when halted; soft reset pulses the logic reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_init <= 1'b1;
      logic_reset <= 1'b0;
    end else begin
      fifo_init <= ~run_d | sw_fire;
      logic_reset <= sw_fire;
    end
  end

  // Gap only when the device drives the clock and buffering or FIFO is on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_clocks <= 7'h00;
    end else begin
      gap_clocks <= (sync_mode & ctl_q[`SCM_CR_CLKOUT] &
                     (ctl_q[`SCM_CR_DBUF] | ctl_q[`SCM_CR_FIFO]))
                    ? gap_decode(mod_b_q[`SCM_B_GAP +: 3]) : `SCM_GAP_NONE;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_rx_gate_off: assert property (@(posedge pclk) disable iff (!presetn)
    !mod_a_q[`SCM_A_RXE] |=> !rx_allow)
    else $error("receive allowed while disabled");
  a_tx_gate_off: assert property (@(posedge pclk) disable iff (!presetn)
    !mod_b_q[`SCM_B_TXE] |=> !tx_allow)
    else $error("transmit allowed while disabled");
  a_cts_gates_tx: assert property (@(posedge pclk) disable iff (!presetn)
    (!sync_mode && mod_a_q[`SCM_A_HSHK] && cts_n) |=> !tx_allow)
    else $error("transmit not held by clear-to-send");
  a_wakeup_filter: assert property (@(posedge pclk) disable iff (!presetn)
    (u9_mode && mod_a_q[`SCM_A_WAKE] && !rx_ninth_bit) |=> !rx_irq)
    else $error("wake-up filter let a character through");
  a_ninth_bit_out: assert property (@(posedge pclk) disable iff (!presetn)
    u9_mode |=> tx_ninth_bit == $past(mod_a_q[`SCM_A_NINTH]))
    else $error("ninth bit not following register");
  a_fifo_reinit: assert property (@(posedge pclk) disable iff (!presetn)
    !ctl_q[`SCM_CR_CHEN] |=> fifo_init)
    else $error("fifo not reinitialised with channel off");
  a_idle_halt: assert property (@(posedge pclk) disable iff (!presetn)
    (sys_idle && !mod_b_q[`SCM_B_IDLE]) |=> !chan_run)
    else $error("channel ran in idle");
  a_soft_reset: assert property (@(posedge pclk) disable iff (!presetn)
    sw_fire |=> (!mod_a_q[`SCM_A_RXE] && !mod_b_q[`SCM_B_TXE]) ##1 logic_reset == 1'b0)
    else $error("soft reset left enables set");
  a_gap_sixty_four: assert property (@(posedge pclk) disable iff (!presetn)
    (sync_mode && ctl_q[`SCM_CR_CLKOUT] && ctl_q[`SCM_CR_DBUF] &&
     mod_b_q[`SCM_B_GAP +: 3] == 3'h7) |=> gap_clocks == `SCM_GAP_C64)
    else $error("gap code 111 not 64 clocks");
  a_sync_clock: assert property (@(posedge pclk) disable iff (!presetn)
    (sync_mode && ctl_q[`SCM_CR_SYNCCLK]) |=> clk_sel == 2'b11)
    else $error("sync clock select not pin");

  // Mode and clock outputs must track the registers one cycle later.
  a_mode_follow: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> mode == $past(mod_a_q[`SCM_A_MODE +: 2]))
    else $error("mode output not following register");

  a_uart_clock: assert property (@(posedge pclk) disable iff (!presetn)
    !sync_mode |=> clk_sel == $past(mod_a_q[`SCM_A_CLKSRC +: 2]))
    else $error("uart clock source not applied");

  a_sync_baud: assert property (@(posedge pclk) disable iff (!presetn)
    (sync_mode && !ctl_q[`SCM_CR_SYNCCLK]) |=> clk_sel == 2'b01)
    else $error("sync clock select not baud generator");

  // The ninth bit is meaningless outside 9-bit frames, so it is held low there.
  a_no_ninth_out: assert property (@(posedge pclk) disable iff (!presetn)
    !u9_mode |=> !tx_ninth_bit)
    else $error("ninth bit driven outside 9-bit mode");

  // Transmit gating: handshake only matters in UART modes with the bit set.
  a_cts_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (!sync_mode && !mod_a_q[`SCM_A_HSHK] && run_d && mod_b_q[`SCM_B_TXE]) |=> tx_allow)
    else $error("transmit blocked with handshake off");

  a_tx_open: assert property (@(posedge pclk) disable iff (!presetn)
    (run_d && mod_b_q[`SCM_B_TXE] && dir_tx_ok && !cts_n) |=> tx_allow)
    else $error("transmit not allowed while enabled");

  a_sync_tx_dir: assert property (@(posedge pclk) disable iff (!presetn)
    (sync_mode && !mod_b_q[`SCM_B_DUPLEX + 1]) |=> !tx_allow)
    else $error("sync transmit outside duplex setting");

  a_sync_rx_dir: assert property (@(posedge pclk) disable iff (!presetn)
    (sync_mode && !mod_b_q[`SCM_B_DUPLEX]) |=> !rx_allow)
    else $error("sync receive outside duplex setting");

  a_uart_rx_dir: assert property (@(posedge pclk) disable iff (!presetn)
    (!sync_mode && run_d && mod_a_q[`SCM_A_RXE]) |=> rx_allow)
    else $error("uart receive limited by duplex field");

  a_fifo_cfg_follow: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> fifo_cfg == $past(mod_b_q[`SCM_B_DUPLEX +: 2]))
    else $error("fifo configuration not following duplex field");

  // Receive interrupt needs a character and an open receiver.
  a_irq_needs_char: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_char_done |=> !rx_irq)
    else $error("receive interrupt without a character");

  a_irq_rx_off: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_allow |=> !rx_irq)
    else $error("receive interrupt with receiver closed");

  a_wake_pass: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_char_done && rx_allow && rx_ninth_bit) |=> rx_irq)
    else $error("addressed character dropped");

  // Run state under the channel enable and the idle run bit.
  a_idle_run: assert property (@(posedge pclk) disable iff (!presetn)
    (ctl_q[`SCM_CR_CHEN] && mod_b_q[`SCM_B_IDLE]) |=> chan_run)
    else $error("channel halted with idle run set");

  a_chan_off: assert property (@(posedge pclk) disable iff (!presetn)
    !ctl_q[`SCM_CR_CHEN] |=> !chan_run)
    else $error("channel running while disabled");

  // A soft reset is a single pulse and also re-initialises the FIFO.
  a_fire_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    sw_fire |=> (logic_reset && fifo_init))
    else $error("soft reset pulse missing");

  a_fire_only: assert property (@(posedge pclk) disable iff (!presetn)
    !sw_fire |=> !logic_reset)
    else $error("logic reset without soft reset");

  // Gap is forced to none wherever it has no meaning.
  a_gap_uart_off: assert property (@(posedge pclk) disable iff (!presetn)
    !sync_mode |=> gap_clocks == `SCM_GAP_NONE)
    else $error("gap applied in uart mode");

  a_gap_no_clkout: assert property (@(posedge pclk) disable iff (!presetn)
    !ctl_q[`SCM_CR_CLKOUT] |=> gap_clocks == `SCM_GAP_NONE)
    else $error("gap applied with clock input");

  a_gap_one: assert property (@(posedge pclk) disable iff (!presetn)
    (sync_mode && ctl_q[`SCM_CR_CLKOUT] && ctl_q[`SCM_CR_FIFO] &&
     mod_b_q[`SCM_B_GAP +: 3] == 3'h1) |=> gap_clocks == `SCM_GAP_C1)
    else $error("gap code 001 not one clock");

  a_gap_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (mod_b_q[`SCM_B_GAP +: 3] == 3'h6) |=> gap_clocks == `SCM_GAP_NONE)
    else $error("reserved gap code gave a gap");

  // Unused bits stay zero on reads and in register b.
  a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");

  a_bit0_zero: assert property (@(posedge pclk) disable iff (!presetn)
    mod_b_q[0] == 1'b0)
    else $error("register b bit 0 set");

endmodule

// >>> core/scm_regs.svh
`ifndef SCM_REGS_SVH
`define SCM_REGS_SVH
`define SCM_ADDR_A 12'h000
`define SCM_ADDR_B 12'h004
`define SCM_ADDR_CR 12'h008
`define SCM_ADDR_ST 12'h00c
`define SCM_A_CLKSRC 0
`define SCM_A_MODE 2
`define SCM_A_WAKE 4
`define SCM_A_RXE 5
`define SCM_A_HSHK 6
`define SCM_A_NINTH 7
`define SCM_B_GAP 1
`define SCM_B_TXE 4
`define SCM_B_DUPLEX 5
`define SCM_B_IDLE 7
`define SCM_CR_SYNCCLK 0
`define SCM_CR_CLKOUT 1
`define SCM_CR_DBUF 2
`define SCM_CR_FIFO 3
`define SCM_CR_CHEN 4
`define SCM_CR_SRST 8
`define SCM_RST_A 8'h00
`define SCM_RST_B 8'h00
`define SCM_RST_CR 9'h000
`define SCM_SRST_FIRST 2'b10
`define SCM_SRST_SECOND 2'b01
`define SCM_GAP_NONE 7'h00
`define SCM_GAP_C1 7'h01
`define SCM_GAP_C2 7'h02
`define SCM_GAP_C4 7'h04
`define SCM_GAP_C8 7'h08
`define SCM_GAP_C16 7'h10
`define SCM_GAP_C64 7'h40
`endif

// >>> core/scm_pkg.sv
package scm_pkg;
  typedef enum logic [1:0] {
    SCM_MODE_SYNC = 2'b00,
    SCM_MODE_U7 = 2'b01,
    SCM_MODE_U8 = 2'b10,
    SCM_MODE_U9 = 2'b11
  } scm_mode_t;
  typedef enum logic [1:0] {
    SCM_CLK_TIMER = 2'b00,
    SCM_CLK_BAUD = 2'b01,
    SCM_CLK_SYS = 2'b10,
    SCM_CLK_PIN = 2'b11
  } scm_clk_t;
  typedef enum logic [1:0] {
    SCM_SR_IDLE = 2'b00,
    SCM_SR_ARMED = 2'b01
  } scm_sr_t;
endpackage

// >>> dv/scm_peer_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Remote serial peer
// ----------------------------------------
module scm_peer_model (
  // Clock and commands from the bench, and transmit allow from the channel.
  input wire logic pclk,
  input wire logic send_req,
  input wire logic send_ninth,
  input wire logic peer_ready,
  input wire logic tx_allow,
  // Lines towards the channel.
  output logic cts_n,
  output logic rx_char_done,
  output logic rx_ninth_bit,
  output logic tx_busy
);
  // Clear-to-send is low while the peer can take data.
  assign cts_n = ~peer_ready;
  // The ninth bit is only valid with the pulse, so otherwise it carries the inverse of send_ninth to expose misuse.
  always_ff @(posedge pclk) begin
    rx_char_done <= send_req;
    rx_ninth_bit <= send_req ? send_ninth : ~send_ninth;
    tx_busy <= tx_allow;
  end
endmodule

// >>> dv/scm_mode_ctrl_tb_top.sv
`timescale 1ns/1ns
`include "scm_regs.svh"
module scm_mode_ctrl_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdv;
  logic sys_idle = 0, cts_n, rx_char_done, rx_ninth_bit, tx_busy, send_req = 0, send_ninth = 0;
  logic peer_ready = 0, tx_ninth_bit, tx_allow, rx_allow, rx_irq, chan_run, fifo_init, lserr;
  logic [1:0] mode, clk_sel, fifo_cfg;
  logic [6:0] gap_clocks;
  int fails = 0, comparisons = 0, irq_cnt = 0, c0;
  scm_mode_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sys_idle(sys_idle), .cts_n(cts_n), .rx_char_done(rx_char_done),
    .rx_ninth_bit(rx_ninth_bit), .tx_busy(tx_busy), .mode(mode), .clk_sel(clk_sel),
    .tx_ninth_bit(tx_ninth_bit), .tx_allow(tx_allow), .rx_allow(rx_allow), .rx_irq(rx_irq),
    .chan_run(chan_run), .fifo_cfg(fifo_cfg), .fifo_init(fifo_init), .logic_reset(),
    .gap_clocks(gap_clocks));
  scm_peer_model peer_u (.pclk(pclk), .send_req(send_req), .send_ninth(send_ninth),
    .peer_ready(peer_ready), .tx_allow(tx_allow), .cts_n(cts_n),
    .rx_char_done(rx_char_done), .rx_ninth_bit(rx_ninth_bit), .tx_busy(tx_busy));
  // Clock at 20 MHz.
  always #25 pclk = ~pclk;
  // Interrupt pulses are counted so that a missing or extra one shows up.
  always @(posedge pclk) if (rx_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One register bus transfer; ready, data and error are all taken at the rising edge.
  task automatic bus_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fails++;
    rdv = prdata;
    lserr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge pclk);
  endtask
  task automatic send(input logic b);
    @(posedge pclk);
    send_req <= 1; send_ninth <= b;
    @(posedge pclk);
    send_req <= 0;
    wt(3);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    bus_xfer(0, `SCM_ADDR_A, 0); chk(rdv, 0);
    bus_xfer(0, `SCM_ADDR_B, 0); chk(rdv, 0);
    bus_xfer(0, `SCM_ADDR_ST, 0); chk(rdv, 1);
    bus_xfer(0, 12'h010, 0); chk(lserr, 1);
    chk(rdv, 0);
  endtask
  // The duplex field sets the FIFO and, in sync mode, the directions; no DMA runs on the interrupts.
  task automatic t_modes;
    for (int i = 0; i < 4; i++) begin
      bus_xfer(1, `SCM_ADDR_CR, i & 1);
      bus_xfer(1, `SCM_ADDR_A, (i << 2) | (3 - i));
      bus_xfer(1, `SCM_ADDR_B, i << 5);
      wt(3);
      chk(mode, i);
      chk(clk_sel, i == 0 ? 1 : 3 - i);
      chk(fifo_cfg, i);
    end
  endtask
  // Gap widths only count in sync mode with the clock driven out and buffering or FIFO on.
  task automatic t_gap;
    int g[8] = '{0, 1, 2, 4, 8, 16, 0, 64};
    bus_xfer(1, `SCM_ADDR_A, 0);
    bus_xfer(1, `SCM_ADDR_CR, 6);
    for (int c = 0; c < 8; c++) begin
      bus_xfer(1, `SCM_ADDR_B, (c << 1) | 1);
      wt(3); chk(gap_clocks, g[c]);
      bus_xfer(0, `SCM_ADDR_B, 0); chk(rdv, c << 1);
    end
    bus_xfer(1, `SCM_ADDR_A, 8'h0c); wt(3); chk(gap_clocks, 0);
  endtask
  // The channel is enabled first, since receive is only allowed while it runs.
  task automatic t_rx;
    bus_xfer(1, `SCM_ADDR_CR, 12'h010);
    bus_xfer(1, `SCM_ADDR_A, 8'h3c); wt(3); chk(rx_allow, 1);
    c0 = irq_cnt; send(0); send(1); chk(irq_cnt - c0, 1);
    bus_xfer(1, `SCM_ADDR_A, 8'h38); c0 = irq_cnt; send(0); chk(irq_cnt - c0, 1);
    bus_xfer(1, `SCM_ADDR_A, 8'h18); c0 = irq_cnt; send(1); chk(irq_cnt - c0, 0);
  endtask
  task automatic t_tx;
    bus_xfer(1, `SCM_ADDR_A, 8'hcc); bus_xfer(1, `SCM_ADDR_B, 8'h10); wt(3);
    chk({tx_allow, tx_ninth_bit}, 2'b01);
    @(posedge pclk) peer_ready <= 1; wt(3); chk(tx_allow, 1);
    @(posedge pclk) peer_ready <= 0;
    bus_xfer(1, `SCM_ADDR_A, 8'h0c); wt(3); chk({tx_allow, tx_ninth_bit}, 2'b10);
    bus_xfer(1, `SCM_ADDR_B, 0); wt(3); chk(tx_allow, 0);
  endtask
  // Soft reset with the channel enabled, then the idle behaviour.
  task automatic t_srst;
    bus_xfer(1, `SCM_ADDR_A, 8'h20); bus_xfer(1, `SCM_ADDR_B, 8'h10);
    bus_xfer(1, `SCM_ADDR_CR, 12'h210); bus_xfer(1, `SCM_ADDR_CR, 12'h110); wt(3);
    chk({rx_allow, tx_allow, fifo_init}, 0);
    bus_xfer(0, `SCM_ADDR_A, 0); chk(rdv, 0);
    bus_xfer(0, `SCM_ADDR_B, 0); chk(rdv, 0);
    @(posedge pclk) sys_idle <= 1; wt(3); chk({chan_run, fifo_init}, 2'b01);
    bus_xfer(1, `SCM_ADDR_B, 8'h80); wt(3); chk(chan_run, 1);
  endtask
  // Watchdog well beyond the few hundred cycles the scenarios need.
  initial begin
    #(50 * 20000);
    fails++;
    give_verdict;
  end
  // Main sequence.
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_reset; t_modes; t_gap; t_rx; t_tx; t_srst;
    give_verdict;
  end
endmodule
